// >>> prot_status_pkg.sv
// constants for the protection and status readout logic of a serial flash
// assumes spi mode 0/3 framing, sampled by a 50 MHz core clock
// ============================================================
// Summary of operation
// - protection read is opcode 3C then three address bytes within the sector.
// - after the last address byte, output data on every following clock.
// - protection read repeats FF for a protected sector, 00 otherwise.
// - chip select release ends protection read and floats the output.
// - protection readout shows only the sector bit, never the guard pin.
// - guard pin low with lock bit set freezes sector bits and lock bit.
// - under hardware lock, protect, unprotect and status writes are ignored.
// - clearing the lock bit never also performs a global protect or unprotect.
// - guard pin low: a set lock bit clears only by reset.
// - guard pin high with lock bit set refuses sector commands and globals.
// - raising the lock bit may also run global protect per bits 5..2.
// - lock clears only with pin high; setting 0 to 1 always allowed.
// - status read is opcode 05, status bits follow on every clock.
// - status reads are served at all times, even while busy.
// - after bit 0 wrap to bit 7 with freshly sampled status.
// - chip select release ends status read and floats the output.
// - bit 7 is the lock bit, default 0; bit 6 reserved, reads 0.
// - bit 5 shows the last program or erase fault.
// - bit 4 mirrors the guard pin: 0 asserted, 1 deasserted.
// - bits 3:2: 00 none, 01 some, 11 all protected; 10 reserved.
// - bit 1 shows the write enable latch.
// - bit 0 shows an internal operation in progress.
// - a status write changes only bit 7 of stored status.
// - lock bit comes up 0 after power-up or reset.
// - status write is opcode 01 plus one data byte framed by chip select.
package prot_status_pkg;
    localparam logic [7:0] OP_READ_PROT = 8'h3C;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] PROT_BYTE_SET = 8'hFF;
    localparam logic [7:0] PROT_BYTE_CLEAR = 8'h00;
    localparam int LOCK_BIT = 7;
    localparam int FAULT_BIT = 5;
    localparam int GUARD_BIT = 4;
    localparam int SUMMARY_LSB = 2;
    localparam int WEL_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam logic [3:0] GLOBAL_UNPROTECT_CODE = 4'h0;
    localparam logic [3:0] GLOBAL_PROTECT_CODE = 4'hF;
    localparam logic [1:0] SUMMARY_NONE = 2'h0;
    localparam logic [1:0] SUMMARY_SOME = 2'h1;
    localparam logic [1:0] SUMMARY_ALL = 2'h3;
    localparam logic LOCK_RESET = 1'b0;
    localparam int SECTOR_COUNT = 16;
    localparam int SECTOR_ADDR_LSB = 17;
    localparam int ADDR_BITS = 24;
    typedef enum logic [2:0] {
        ST_OPCODE, ST_ADDR, ST_PROT_OUT, ST_STAT_OUT, ST_WDATA, ST_IGNORE
    } phase_t;
endpackage

// >>> flash_protect_status.sv
// protection readout, lock matrix and status readout for a serial flash
// assumes spi pins arrive asynchronously; core clock well above sck rate
`timescale 1ns/10ps
module flash_protect_status #(
    parameter int SECTORS = prot_status_pkg::SECTOR_COUNT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    // guard pin, active low
    input wire logic guard_n,
    // array engine side
    input wire logic op_busy,
    input wire logic op_fault,
    input wire logic write_enable_latch,
    input wire logic sector_cmd_req,
    input wire logic sector_cmd_set,
    input wire logic [prot_status_pkg::ADDR_BITS-1:0] sector_cmd_addr,
    output logic sector_cmd_done,
    output logic wel_clear,
    output logic protection_lock_bit,
    output logic [SECTORS-1:0] sector_prot
);
    import prot_status_pkg::*;

    // ============================================================
    // pin synchronisers
    logic [1:0] cs_sync_reg, sck_sync_reg, si_sync_reg, guard_sync_reg;
    logic sck_prev_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_sync_reg <= 2'h3;
            sck_sync_reg <= 2'h0;
            si_sync_reg <= 2'h0;
            guard_sync_reg <= 2'h3;
            sck_prev_reg <= 1'b0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], cs_n};
            sck_sync_reg <= {sck_sync_reg[0], sck};
            si_sync_reg <= {si_sync_reg[0], si};
            guard_sync_reg <= {guard_sync_reg[0], guard_n};
            sck_prev_reg <= sck_sync_reg[1];
        end
    end

    wire cs_active = !cs_sync_reg[1];
    wire sck_rise = sck_sync_reg[1] && !sck_prev_reg;
    wire sck_fall = !sck_sync_reg[1] && sck_prev_reg;
    wire si_bit = si_sync_reg[1];
    wire guard_low = !guard_sync_reg[1];

    // ============================================================
    // frame state
    phase_t phase_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_cnt_reg;
    logic [ADDR_BITS-1:0] addr_reg;
    logic [7:0] out_reg;
    logic [7:0] wdata_reg;
    logic wdata_full_reg;
    logic wsr_seen_reg;
    logic lock_reg;
    logic [SECTORS-1:0] prot_reg;

    function automatic logic [1:0] summarize(input logic [SECTORS-1:0] p);
        if (&p) summarize = SUMMARY_ALL;
        else if (|p) summarize = SUMMARY_SOME;
        else summarize = SUMMARY_NONE;
    endfunction

    // ============================================================
    // decode
    wire [7:0] shifted = {shift_reg[6:0], si_bit};
    wire byte_done = sck_rise && (bit_cnt_reg == 3'h7);
    wire hw_locked = guard_low && lock_reg;
    wire [$clog2(SECTORS)-1:0] sel_sector =
        addr_reg[SECTOR_ADDR_LSB +: $clog2(SECTORS)];
    wire [$clog2(SECTORS)-1:0] cmd_sector =
        sector_cmd_addr[SECTOR_ADDR_LSB +: $clog2(SECTORS)];
    // pin level only in bit 4; sector readout never sees it
    wire [7:0] status_now = {lock_reg, 1'b0, op_fault, !guard_low,
        summarize(prot_reg), write_enable_latch, op_busy};
    wire [7:0] prot_byte = prot_reg[sel_sector] ? PROT_BYTE_SET : PROT_BYTE_CLEAR;
    wire [3:0] global_code = wdata_reg[5:2];
    wire new_lock = wdata_reg[LOCK_BIT];
    // status write applied at the chip-select release after a full byte
    wire wsr_end = (phase_reg == ST_WDATA || phase_reg == ST_IGNORE) && !cs_active
        && wsr_seen_reg;
    wire wsr_ok = wsr_end && wdata_full_reg && write_enable_latch && !hw_locked
        && !(guard_low && lock_reg && !new_lock);
    // globals only while unlocked beforehand
    wire do_global = wsr_ok && !lock_reg;
    wire global_set = do_global && (global_code == GLOBAL_PROTECT_CODE);
    wire global_clr = do_global && (global_code == GLOBAL_UNPROTECT_CODE);
    wire sector_ok = sector_cmd_req && !lock_reg;

    // ============================================================
    // command sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= ST_OPCODE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 2'h0;
            addr_reg <= '0;
            wdata_full_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wsr_seen_reg <= 1'b0;
        end else if (!cs_active) begin
            phase_reg <= ST_OPCODE;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 2'h0;
            wdata_full_reg <= 1'b0;
            wsr_seen_reg <= 1'b0;
        end else if (sck_rise) begin
            shift_reg <= shifted;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done) begin
                case (phase_reg)
                    ST_OPCODE: begin
                        if (shifted == OP_READ_PROT) phase_reg <= ST_ADDR;
                        else if (shifted == OP_READ_STATUS) phase_reg <= ST_STAT_OUT;
                        else if (shifted == OP_WRITE_STATUS) begin
                            phase_reg <= ST_WDATA;
                            wsr_seen_reg <= 1'b1;
                        end else phase_reg <= ST_IGNORE;
                    end
                    ST_ADDR: begin
                        addr_reg <= {addr_reg[ADDR_BITS-9:0], shifted};
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                        if (byte_cnt_reg == 2'h2) phase_reg <= ST_PROT_OUT;
                    end
                    ST_WDATA: begin
                        wdata_reg <= shifted;
                        wdata_full_reg <= 1'b1;
                        phase_reg <= ST_IGNORE;          // extra bytes dropped
                    end
                    default: phase_reg <= phase_reg;
                endcase
            end
        end
    end

    // ============================================================
    // serial output, shifted on falling sck
    // status reloaded each byte so polling sees fresh busy
    wire out_active = (phase_reg == ST_STAT_OUT) || (phase_reg == ST_PROT_OUT);
    wire [7:0] out_load = (phase_reg == ST_STAT_OUT) ? status_now : prot_byte;
    wire [7:0] out_src = (bit_cnt_reg == 3'h0) ? out_load : out_reg;
    wire [7:0] out_next = {out_src[6:0], 1'b0};
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg <= 8'h00;
            so_out <= 1'b0;
            so_oe <= 1'b0;
        end else if (!cs_active) begin
            so_oe <= 1'b0;
        end else if (sck_fall && out_active) begin
            so_oe <= 1'b1;
            so_out <= out_src[7];
            out_reg <= out_next;
        end
    end

    // ============================================================
    // lock bit and sector protection store
    // a global write owns the whole array, so it wins over a sector command
    wire lock_next = wsr_ok ? new_lock : lock_reg;
    wire [SECTORS-1:0] sector_mask = {{(SECTORS-1){1'b0}}, 1'b1} << cmd_sector;
    wire [SECTORS-1:0] sector_merge = sector_cmd_set ? (prot_reg | sector_mask)
        : (prot_reg & ~sector_mask);
    wire [SECTORS-1:0] prot_next = global_set ? {SECTORS{1'b1}}
        : global_clr ? {SECTORS{1'b0}}
        : sector_ok ? sector_merge : prot_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_reg <= LOCK_RESET;
        end else begin
            lock_reg <= lock_next;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prot_reg <= '1;
        end else begin
            prot_reg <= prot_next;
        end
    end

    // done acknowledges refused commands too, so the engine never waits
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sector_cmd_done <= 1'b0;
            wel_clear <= 1'b0;
        end else begin
            sector_cmd_done <= sector_cmd_req;
            wel_clear <= wsr_end;
        end
    end

    assign protection_lock_bit = lock_reg;
    assign sector_prot = prot_reg;
endmodule

// >>> spi_host_model.sv
// spi host model: drives cs, sck and si, samples so
// assumes a 20 ns core clock; sck period is 180 ns
`timescale 1ns/10ps
module spi_host_model (
    // clock
    input wire logic core_clk,
    // serial pins
    output logic cs_n = 1'b1,
    output logic sck = 1'b0,
    output logic si = 1'b0,
    input wire logic so_out,
    input wire logic so_oe
);
    // =====
    // frames
    // gap before each frame keeps cs high well over four core clocks
    task automatic frame_on();
        repeat (6) @(posedge core_clk);
        cs_n <= 1'b0;
    endtask
    // released data line shows the inverse, not a stale value
    task automatic frame_off();
        @(posedge core_clk);
        cs_n <= 1'b1;
        si <= ~si;
    endtask
    // sck idles low, bytes go msb first; a floated so reads as unknown
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            @(posedge core_clk);
            si <= tx[i];
            repeat (4) @(posedge core_clk);
            sck <= 1'b1;
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            rx[i] = so_oe ? so_out : 1'bx;
            @(posedge core_clk);
            sck <= 1'b0;
        end
    endtask
endmodule

// >>> flash_protect_status_properties.sv
// port assertions for flash_protect_status
// assumes sck phases of at least four core clocks
`timescale 1ns/10ps
module flash_protect_status_properties #(
    parameter int SECTORS = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // pins
    input wire logic cs_n,
    input wire logic so_oe,
    input wire logic guard_n,
    // engine side
    input wire logic sector_cmd_req,
    input wire logic sector_cmd_set,
    input wire logic [23:0] sector_cmd_addr,
    input wire logic protection_lock_bit,
    input wire logic [SECTORS-1:0] sector_prot
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // =====
    // lock matrix
    a_lock_freezes_sectors: assert property (
        protection_lock_bit && $past(protection_lock_bit) |-> $stable(sector_prot)
    ) else $error("sector bits moved while locked");
    a_clear_no_global: assert property (
        $fell(protection_lock_bit) |-> $stable(sector_prot)
    ) else $error("global change with lock clear");
    a_pin_holds_lock: assert property (
        (!guard_n) [*6] |-> !$fell(protection_lock_bit)
    ) else $error("lock cleared with guard pin low");
    a_sector_cmd_taken: assert property (
        sector_cmd_req && !protection_lock_bit ##2 1 |->
        sector_prot[$past(sector_cmd_addr[20:17], 2)] == $past(sector_cmd_set, 2)
    ) else $error("unlocked sector command lost");
    a_lock_reset_low: assert property (
        !$past(arst_n) |-> !protection_lock_bit
    ) else $error("lock bit set after reset");
    a_lock_at_frame_end: assert property (
        $changed(protection_lock_bit) |-> cs_n
    ) else $error("lock moved inside a frame");
    // =====
    // serial output
    a_oe_idle_off: assert property (
        cs_n [*6] |-> !so_oe
    ) else $error("so driven without chip select");
    a_oe_in_frame: assert property (
        $rose(so_oe) |-> !cs_n && !$past(cs_n, 40)
    ) else $error("so enabled outside a command");
    cover property ($fell(protection_lock_bit));
    cover property ($rose(so_oe));
    cover property (sector_cmd_req && protection_lock_bit);
endmodule
bind flash_protect_status flash_protect_status_properties #(.SECTORS(SECTORS)) chk (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .cs_n(cs_n),
    .so_oe(so_oe),
    .guard_n(guard_n),
    .sector_cmd_req(sector_cmd_req),
    .sector_cmd_set(sector_cmd_set),
    .sector_cmd_addr(sector_cmd_addr),
    .protection_lock_bit(protection_lock_bit),
    .sector_prot(sector_prot)
);

// >>> test_flash_protect_status.sv
// self-checking bench for flash_protect_status
// assumes the host model and the bound checker are compiled first
`timescale 1ns/10ps
module test_flash_protect_status;
    import prot_status_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic guard_n = 1'b1;
    logic op_busy = 1'b0;
    logic op_fault = 1'b0;
    logic write_enable_latch = 1'b0;
    logic sector_cmd_req = 1'b0;
    logic sector_cmd_set = 1'b0;
    logic [23:0] sector_cmd_addr = 24'h000000;
    logic cs_n, sck, si, so_out, so_oe, wel_clear, protection_lock_bit;
    logic sector_cmd_done;
    logic [15:0] sector_prot;
    logic [15:0] prot_m = 16'hFFFF;
    logic lock_m = 1'b0;
    logic [7:0] rx;
    int errors = 0;
    int check_count = 0;
    int seed = 32'hE22B9F87;
    always #10 core_clk = ~core_clk;
    flash_protect_status DUT (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .so_out(so_out),
        .so_oe(so_oe),
        .guard_n(guard_n),
        .op_busy(op_busy),
        .op_fault(op_fault),
        .write_enable_latch(write_enable_latch),
        .sector_cmd_req(sector_cmd_req),
        .sector_cmd_set(sector_cmd_set),
        .sector_cmd_addr(sector_cmd_addr),
        .sector_cmd_done(sector_cmd_done),
        .wel_clear(wel_clear),
        .protection_lock_bit(protection_lock_bit),
        .sector_prot(sector_prot)
    );
    spi_host_model host (
        .core_clk(core_clk),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .so_out(so_out),
        .so_oe(so_oe)
    );
    // =====
    // expectations and reporting
    function automatic logic [7:0] exp_st();
        logic [1:0] sm;
        sm = (prot_m == 16'h0000) ? SUMMARY_NONE : ((&prot_m) ? SUMMARY_ALL : SUMMARY_SOME);
        return {lock_m, 1'b0, op_fault, guard_n, sm, write_enable_latch, op_busy};
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // =====
    // commands; busy and fault change per byte, so each byte is fresh
    task automatic rd_st(input int n);
        host.frame_on();
        host.xfer(OP_READ_STATUS, 8, rx);
        repeat (n) begin
            {op_busy, op_fault} <= 2'($random(seed));
            host.xfer(8'($random(seed)), 8, rx);
            check("status", {8'h00, rx}, {8'h00, exp_st()});
        end
        host.xfer(8'h00, 5, rx);
        check("status part", {8'h00, 3'h0, rx[7:3]}, {8'h00, exp_st() >> 3});
        host.frame_off();
    endtask
    task automatic rd_pr(input logic [3:0] s);
        logic [23:0] a;
        a = {3'h0, s, 17'($random(seed))};
        host.frame_on();
        host.xfer(OP_READ_PROT, 8, rx);
        for (int i = 2; i >= 0; i--) begin
            host.xfer(a[8*i+:8], 8, rx);
        end
        repeat (2) begin
            host.xfer(8'($random(seed)), 8, rx);
            check("prot byte", {8'h00, rx}, prot_m[s] ? 16'h00FF : 16'h0000);
        end
        host.xfer(8'h00, 3, rx);
        check("prot part", {13'h0000, rx[7:5]}, prot_m[s] ? 16'h0007 : 16'h0000);
        host.frame_off();
    endtask
    task automatic wr(input logic [7:0] d, input int nb);
        int k;
        host.frame_on();
        host.xfer(OP_WRITE_STATUS, 8, rx);
        host.xfer(d, nb, rx);
        host.frame_off();
        for (k = 0; k < 20 && wel_clear !== 1'b1; k++) @(negedge core_clk);
        if (k == 20) begin
            errors++;
            results();
        end
        if (nb == 8 && write_enable_latch && !(lock_m && !guard_n)) begin
            if (!lock_m && d[5:2] == GLOBAL_PROTECT_CODE) prot_m = 16'hFFFF;
            if (!lock_m && d[5:2] == GLOBAL_UNPROTECT_CODE) prot_m = 16'h0000;
            lock_m = d[7];
        end
        write_enable_latch <= 1'b0;
        @(negedge core_clk);
        check("wel pulse", {15'h0000, wel_clear}, 16'h0000);
        repeat (2) @(posedge core_clk);
        check("lock", {15'h0000, protection_lock_bit}, {15'h0000, lock_m});
        check("sectors", sector_prot, prot_m);
    endtask
    task automatic sc(input logic [3:0] s, input logic v);
        @(posedge core_clk);
        sector_cmd_req <= 1'b1;
        sector_cmd_set <= v;
        sector_cmd_addr <= {3'h0, s, 17'($random(seed))};
        @(posedge core_clk);
        sector_cmd_req <= 1'b0;
        if (!lock_m) prot_m[s] = v;
        @(negedge core_clk);
        check("cmd done", {15'h0000, sector_cmd_done}, 16'h0001);
        repeat (3) @(posedge core_clk);
        check("sectors", sector_prot, prot_m);
    endtask
    // =====
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rd_st(2);
        rd_pr(4'h0);
        rd_pr(4'hF);
        write_enable_latch <= 1'b1;
        wr(8'h00, 8);
        sc(4'h3, 1'b1);
        guard_n <= 1'b0;
        rd_st(1);
        rd_pr(4'h3);
        rd_pr(4'h4);
        guard_n <= 1'b1;
        write_enable_latch <= 1'b1;
        wr(8'hBC, 8);
        sc(4'h5, 1'b0);
        guard_n <= 1'b0;
        write_enable_latch <= 1'b1;
        wr(8'h00, 8);
        sc(4'h6, 1'b0);
        guard_n <= 1'b1;
        write_enable_latch <= 1'b1;
        wr(8'h00, 8);
        wr(8'h80, 8);
        write_enable_latch <= 1'b1;
        wr(8'h80, 4);
        guard_n <= 1'b0;
        write_enable_latch <= 1'b1;
        wr(8'h80, 8);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        lock_m = 1'b0;
        prot_m = 16'hFFFF;
        rd_st(1);
        repeat (6) begin
            {guard_n, write_enable_latch} <= 2'($random(seed));
            sc(4'($random(seed)), 1'($random(seed)));
            rd_st(2);
            rd_pr(4'($random(seed)));
        end
        results();
    end
endmodule
